// ---- logic/ptad_defines.vh ----
// constants for the pager time and address decoder
`ifndef PTAD_DEFINES_VH
`define PTAD_DEFINES_VH
// information word function codes and system-message time subtypes
`define PTAD_FC_TIME 3'h2
`define PTAD_FC_SYSMSG 3'h5
`define PTAD_SM_TIME_A 4'h4
`define PTAD_SM_TIME_B 4'h5
// field positions inside the 14-bit content field
`define PTAD_CSEC_HI 13
`define PTAD_CSEC_LO 11
`define PTAD_MIN_HI 10
`define PTAD_MIN_LO 5
`define PTAD_HOUR_HI 4
`define PTAD_HOUR_LO 0
`define PTAD_ASEC_HI 13
`define PTAD_ASEC_LO 11
`define PTAD_DST_BIT 9
`define PTAD_ZONE_HI 8
`define PTAD_ZONE_LO 4
`define PTAD_SUB_HI 3
`define PTAD_SUB_LO 0
// legal field maxima
`define PTAD_MINUTE_MAX 6'h3b
`define PTAD_HOUR_MAX 5'h17
// zone codes with special meaning
`define PTAD_ZONE_POS_MAX 5'h0c
`define PTAD_ZONE_NEG_MIN 5'h15
`define PTAD_ZONE_RSVD 5'h10
// address word range limits (inclusive upper ends)
`define PTAD_AW_IDLE_LO 21'h000000
`define PTAD_AW_IDLE_HI 21'h1fffff
`define PTAD_AW_LONG1_HI 21'h008000
`define PTAD_AW_SHORT_HI 21'h1e0000
`define PTAD_AW_LONG3_HI 21'h1e8000
`define PTAD_AW_LONG4_HI 21'h1f0000
`define PTAD_AW_SRES1_HI 21'h1f27ff
`define PTAD_AW_INFO_HI 21'h1f67ff
`define PTAD_AW_NET_HI 21'h1f77ff
`define PTAD_AW_TEMP_HI 21'h1f780f
`define PTAD_AW_OPER_HI 21'h1f781f
`define PTAD_AW_SRES2_HI 21'h1f7ffe
// address classes
`define PTAD_CL_IDLE 4'h0
`define PTAD_CL_LONG1 4'h1
`define PTAD_CL_SHORT 4'h2
`define PTAD_CL_LONG3 4'h3
`define PTAD_CL_LONG4 4'h4
`define PTAD_CL_SRES 4'h5
`define PTAD_CL_INFO 4'h6
`define PTAD_CL_NET 4'h7
`define PTAD_CL_TEMP 4'h8
`define PTAD_CL_OPER 4'h9
`define PTAD_CL_LONG2 4'ha
// address types for phase handling
`define PTAD_AT_SINGLE 2'h0
`define PTAD_AT_ANY 2'h1
`define PTAD_AT_ALL 2'h2
// register byte offsets
`define PTAD_REG_CFG 5'h00
`define PTAD_REG_TIME 5'h04
`define PTAD_REG_ZONE 5'h08
`define PTAD_REG_ASTAT 5'h0c
`define PTAD_REG_AW1 5'h10
`define PTAD_REG_AW2 5'h14
`define PTAD_REG_FRAME 5'h18
// config reset value: frame 0, battery cycle 4, phase 0, single-phase
`define PTAD_CFG_RESET 32'h0000_0400
`endif

// ---- logic/ptad_addr_class.v ----
// classifies one 21-bit address code word into its range
`timescale 1ns/1ps
`include "ptad_defines.vh"
module ptad_addr_class (
   // word in
   input wire [20:0] word,
   // class out
   output reg [3:0] cls
);
   always @* begin
      if (word == `PTAD_AW_IDLE_LO || word == `PTAD_AW_IDLE_HI) begin
         cls = `PTAD_CL_IDLE;
      end else if (word <= `PTAD_AW_LONG1_HI) begin
         cls = `PTAD_CL_LONG1;
      end else if (word <= `PTAD_AW_SHORT_HI) begin
         cls = `PTAD_CL_SHORT;
      end else if (word <= `PTAD_AW_LONG3_HI) begin
         cls = `PTAD_CL_LONG3;
      end else if (word <= `PTAD_AW_LONG4_HI) begin
         cls = `PTAD_CL_LONG4;
      end else if (word <= `PTAD_AW_SRES1_HI) begin
         cls = `PTAD_CL_SRES;
      end else if (word <= `PTAD_AW_INFO_HI) begin
         cls = `PTAD_CL_INFO;
      end else if (word <= `PTAD_AW_NET_HI) begin
         cls = `PTAD_CL_NET;
      end else if (word <= `PTAD_AW_TEMP_HI) begin
         cls = `PTAD_CL_TEMP;
      end else if (word <= `PTAD_AW_OPER_HI) begin
         cls = `PTAD_CL_OPER;
      end else if (word <= `PTAD_AW_SRES2_HI) begin
         cls = `PTAD_CL_SRES;
      end else begin
         cls = `PTAD_CL_LONG2;
      end
   end
endmodule

// ---- logic/ptad_zone_map.v ----
// maps a 5-bit zone code to a signed offset from gmt in minutes
`timescale 1ns/1ps
`include "ptad_defines.vh"
module ptad_zone_map (
   // code in
   input wire [4:0] zone,
   // offset out, two's complement minutes
   output reg [10:0] offset_min,
   output reg reserved
);
   reg [10:0] hours;
   always @* begin
      hours = 11'h000;
      reserved = 1'b0;
      offset_min = 11'h000;
      if (zone <= `PTAD_ZONE_POS_MAX) begin
         hours = {6'h00, zone};
         offset_min = hours * 11'h03c;
      end else if (zone >= `PTAD_ZONE_NEG_MIN) begin
         // codes count upward toward gmt, so minus (32 - code) hours
         hours = {6'h00, zone} - 11'h020;
         offset_min = hours * 11'h03c;
      end else begin
         case (zone)
            5'h0d: offset_min = 11'h0d2;
            5'h0e: offset_min = 11'h10e;
            5'h0f: offset_min = 11'h14a;
            5'h11: offset_min = 11'h159;
            5'h12: offset_min = 11'h186;
            5'h13: offset_min = 11'h23a;
            5'h14: offset_min = 11'h72e;
            default: begin
               offset_min = 11'h000;
               reserved = 1'b1;
            end
         endcase
      end
   end
endmodule

// ---- logic/ptad_top.v ----
// pager time word and address word decoder with frame watch logic
`timescale 1ns/1ps
`include "ptad_defines.vh"
// How it works
// - time word splits into seconds, minute, hour
// - coarse seconds count eighths of a minute
// - minute is binary, valid 0 to 59
// - hour is binary, valid 0 to 23
// - system subtypes 4,5 carry seconds, flag, zone
// - other system subtypes never touch time
// - accurate sixty-fourths add to coarse seconds
// - flag one standard time, zero daylight
// - zone codes give whole-hour gmt offsets
// - special half-hour zones and one 5:45 zone (code 10001), code 10000 reserved
// - idle, long1, short, long3, long4 ranges
// - upper ranges: service, network, temporary, operator
// - short one word, long two words
// - only pairs 1-2,1-3,1-4,2-3,2-4 accepted
// - phase search follows single, any, all type
// - watch assigned frame every 2^b frames
// - frame numbers wrap modulo 128
module ptad_top (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // information word from the receiver channel
   input wire iw_valid,
   input wire [2:0] info_word_function_code,
   input wire [13:0] iw_content,
   // address code word from the receiver channel
   input wire aw_valid,
   input wire [20:0] aw_word,
   // frame timing
   input wire frame_start,
   input wire [6:0] frame_num,
   input wire [1:0] phase_num,
   input wire msg_found,
   // register port
   input wire [4:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   // decoded time
   output reg time_upd_q,
   output reg [2:0] coarse_sec_q,
   output reg [5:0] minute_q,
   output reg [4:0] hour_q,
   output reg [5:0] seconds_q,
   output reg time_bad_q,
   // decoded zone
   output reg zone_upd_q,
   output reg std_time_q,
   output reg [4:0] zone_code_q,
   output reg [10:0] zone_off_q,
   output reg zone_rsvd_q,
   // decoded address
   output reg addr_short_q,
   output reg addr_long_q,
   output reg addr_err_q,
   output reg [3:0] addr_class_q,
   // frame and phase search
   output reg frame_watch_q,
   output reg phase_seek_q
);
   localparam AS_FIRST = 1'b0;
   localparam AS_SECOND = 1'b1;
   // configuration written by software
   reg [6:0] cfg_frame_q;
   reg [2:0] cfg_bcyc_q;
   reg [1:0] cfg_phase_q;
   reg [1:0] cfg_atype_q;

   // time state
   reg [2:0] acc_sec_q;
   reg time_seen_q;
   reg zone_seen_q;
   // address state
   reg as_state_q;
   reg [3:0] first_cls_q;
   reg [20:0] aw1_q;
   reg [20:0] aw2_q;
   reg [7:0] short_cnt_q;
   reg [7:0] long_cnt_q;
   reg [7:0] err_cnt_q;
   // phase state
   reg taken_q;
   reg [1:0] taken_phase_q;

   wire [3:0] aw_cls;
   wire [10:0] zone_off;
   wire zone_rsvd;

   ptad_addr_class u_class (
      .word(aw_word),
      .cls(aw_cls)
   );

   ptad_zone_map u_zone (
      .zone(iw_content[`PTAD_ZONE_HI:`PTAD_ZONE_LO]),
      .offset_min(zone_off),
      .reserved(zone_rsvd)
   );

   // ---- information word decode ----
   wire [3:0] iw_sub = iw_content[`PTAD_SUB_HI:`PTAD_SUB_LO];
   wire is_time = iw_valid && (info_word_function_code == `PTAD_FC_TIME);
   wire is_sysmsg = iw_valid && (info_word_function_code == `PTAD_FC_SYSMSG);
   // only the two time subtypes may update anything here
   wire is_zone = is_sysmsg &&
      (iw_sub == `PTAD_SM_TIME_A || iw_sub == `PTAD_SM_TIME_B);

   wire [2:0] new_csec = iw_content[`PTAD_CSEC_HI:`PTAD_CSEC_LO];
   wire [5:0] new_min = iw_content[`PTAD_MIN_HI:`PTAD_MIN_LO];
   wire [4:0] new_hour = iw_content[`PTAD_HOUR_HI:`PTAD_HOUR_LO];
   wire [2:0] new_asec = iw_content[`PTAD_ASEC_HI:`PTAD_ASEC_LO];

   // the coarse and fine parts may arrive in either order; use the newest of each
   wire [2:0] csec_use = is_time ? new_csec : coarse_sec_q;
   wire [2:0] asec_use = is_zone ? new_asec : acc_sec_q;
   // 64ths of a minute: eighths become 8/64, then 60/64 s per unit
   wire [5:0] units = {csec_use, 3'h0} + {3'h0, asec_use};
   wire [9:0] units_x15 = {4'h0, units} * 10'h00f;
   wire [5:0] sec_d = units_x15[9:4];

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         time_upd_q <= 1'b0;
         coarse_sec_q <= 3'h0;
         minute_q <= 6'h00;
         hour_q <= 5'h00;
         time_bad_q <= 1'b0;
         time_seen_q <= 1'b0;
         seconds_q <= 6'h00;
         zone_upd_q <= 1'b0;
         acc_sec_q <= 3'h0;
         std_time_q <= 1'b0;
         zone_code_q <= 5'h00;
         zone_off_q <= 11'h000;
         zone_rsvd_q <= 1'b0;
         zone_seen_q <= 1'b0;
      end else begin
         time_upd_q <= is_time;
         zone_upd_q <= is_zone;
         if (is_time) begin
            coarse_sec_q <= new_csec;
            minute_q <= new_min;
            hour_q <= new_hour;
            // out-of-range values are passed on but marked
            time_bad_q <= (new_min > `PTAD_MINUTE_MAX) || (new_hour > `PTAD_HOUR_MAX);
            time_seen_q <= 1'b1;
         end
         if (is_zone) begin
            acc_sec_q <= new_asec;
            std_time_q <= iw_content[`PTAD_DST_BIT];
            zone_code_q <= iw_content[`PTAD_ZONE_HI:`PTAD_ZONE_LO];
            zone_off_q <= zone_off;
            zone_rsvd_q <= zone_rsvd;
            zone_seen_q <= 1'b1;
         end
         if (is_time || is_zone) begin
            seconds_q <= sec_d;
         end
      end
   end

   // ---- address word sequencing ----
   wire cls_long_first = (aw_cls == `PTAD_CL_LONG1) || (aw_cls == `PTAD_CL_LONG2);
   wire cls_single = (aw_cls == `PTAD_CL_SHORT) || (aw_cls == `PTAD_CL_SRES) ||
      (aw_cls == `PTAD_CL_INFO) || (aw_cls == `PTAD_CL_NET) ||
      (aw_cls == `PTAD_CL_TEMP) || (aw_cls == `PTAD_CL_OPER);
   reg pair_ok;
   always @* begin
      pair_ok = 1'b0;
      if (first_cls_q == `PTAD_CL_LONG1) begin
         pair_ok = (aw_cls == `PTAD_CL_LONG2) || (aw_cls == `PTAD_CL_LONG3) ||
            (aw_cls == `PTAD_CL_LONG4);
      end else if (first_cls_q == `PTAD_CL_LONG2) begin
         pair_ok = (aw_cls == `PTAD_CL_LONG3) || (aw_cls == `PTAD_CL_LONG4);
      end
   end

   reg as_state_d;
   reg short_d;
   reg long_d;
   reg err_d;
   reg load1_d;
   reg load2_d;
   always @* begin
      as_state_d = as_state_q;
      short_d = 1'b0;
      long_d = 1'b0;
      err_d = 1'b0;
      load1_d = 1'b0;
      load2_d = 1'b0;
      if (aw_valid) begin
         case (as_state_q)
            AS_FIRST: begin
               if (cls_single) begin
                  short_d = 1'b1;
                  load1_d = 1'b1;
               end else if (cls_long_first) begin
                  load1_d = 1'b1;
                  as_state_d = AS_SECOND;
               end else begin
                  // idle word, or long 3/4 with no first word before it
                  err_d = 1'b1;
               end
            end
            AS_SECOND: begin
               if (pair_ok) begin
                  long_d = 1'b1;
                  load2_d = 1'b1;
                  as_state_d = AS_FIRST;
               end else begin
                  // a bad second word aborts; it is not reused as a new first word
                  err_d = 1'b1;
                  as_state_d = AS_FIRST;
               end
            end
            default: begin
               as_state_d = AS_FIRST;
            end
         endcase
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         as_state_q <= AS_FIRST;
         first_cls_q <= `PTAD_CL_IDLE;
         aw1_q <= 21'h000000;
         aw2_q <= 21'h000000;
         addr_short_q <= 1'b0;
         addr_long_q <= 1'b0;
         addr_err_q <= 1'b0;
         addr_class_q <= `PTAD_CL_IDLE;
         short_cnt_q <= 8'h00;
         long_cnt_q <= 8'h00;
         err_cnt_q <= 8'h00;
      end else begin
         as_state_q <= as_state_d;
         addr_short_q <= short_d;
         addr_long_q <= long_d;
         addr_err_q <= err_d;
         if (aw_valid) begin
            addr_class_q <= aw_cls;
         end
         if (load1_d) begin
            aw1_q <= aw_word;
            first_cls_q <= aw_cls;
         end
         if (load2_d) begin
            aw2_q <= aw_word;
         end
         // counters saturate so software can tell overflow from wrap
         if (short_d && short_cnt_q != 8'hff) begin
            short_cnt_q <= short_cnt_q + 8'h01;
         end
         if (long_d && long_cnt_q != 8'hff) begin
            long_cnt_q <= long_cnt_q + 8'h01;
         end
         if (err_d && err_cnt_q != 8'hff) begin
            err_cnt_q <= err_cnt_q + 8'h01;
         end
      end
   end

   // ---- frame watch ----
   wire [6:0] frame_diff = frame_num - cfg_frame_q;
   wire [7:0] period = 8'h01 << cfg_bcyc_q;
   wire [7:0] mask_w = period - 8'h01;
   wire watch_now = (frame_diff & mask_w[6:0]) == 7'h00;

   // ---- phase search ----
   reg seek_d;
   always @* begin
      seek_d = 1'b0;
      case (cfg_atype_q)
         `PTAD_AT_SINGLE: seek_d = frame_watch_q && (phase_num == cfg_phase_q);
         `PTAD_AT_ANY: seek_d = frame_watch_q && (!taken_q || taken_phase_q == phase_num);
         default: seek_d = frame_watch_q;
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_watch_q <= 1'b0;
         phase_seek_q <= 1'b0;
         taken_q <= 1'b0;
         taken_phase_q <= 2'h0;
      end else begin
         phase_seek_q <= seek_d;
         if (frame_start) begin
            frame_watch_q <= watch_now;
            taken_q <= 1'b0;
         end else if (msg_found && !taken_q && frame_watch_q) begin
            // any-phase: the first phase with our message owns the frame
            taken_q <= 1'b1;
            taken_phase_q <= phase_num;
         end
      end
   end

   // ---- register port ----
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_frame_q <= 7'h00;
         cfg_bcyc_q <= 3'h4;
         cfg_phase_q <= 2'h0;
         cfg_atype_q <= `PTAD_AT_SINGLE;
      end else if (reg_wr && reg_addr == `PTAD_REG_CFG) begin
         cfg_frame_q <= reg_wdata[6:0];
         cfg_bcyc_q <= reg_wdata[10:8];
         cfg_phase_q <= reg_wdata[13:12];
         cfg_atype_q <= reg_wdata[17:16];
      end
   end

   reg [31:0] rdata_d;
   always @* begin
      rdata_d = 32'h0000_0000;
      if (reg_addr == `PTAD_REG_CFG) begin
         rdata_d = {14'h0000, cfg_atype_q, 2'h0, cfg_phase_q, 1'b0, cfg_bcyc_q,
            1'b0, cfg_frame_q};
      end else if (reg_addr == `PTAD_REG_TIME) begin
         rdata_d = {time_seen_q, time_bad_q, 2'h0, seconds_q, 1'b0, hour_q,
            2'h0, minute_q, 5'h00, coarse_sec_q};
      end else if (reg_addr == `PTAD_REG_ZONE) begin
         rdata_d = {zone_seen_q, zone_rsvd_q, 3'h0, zone_off_q, 3'h0, zone_code_q,
            3'h0, std_time_q, 1'b0, acc_sec_q};
      end else if (reg_addr == `PTAD_REG_ASTAT) begin
         rdata_d = {err_cnt_q, long_cnt_q, short_cnt_q, 3'h0, as_state_q, addr_class_q};
      end else if (reg_addr == `PTAD_REG_AW1) begin
         rdata_d = {11'h000, aw1_q};
      end else if (reg_addr == `PTAD_REG_AW2) begin
         rdata_d = {11'h000, aw2_q};
      end else if (reg_addr == `PTAD_REG_FRAME) begin
         rdata_d = {22'h000000, frame_watch_q, taken_q, taken_phase_q, 1'b0,
            cfg_bcyc_q, 2'h0};
      end
   end

   // read data stand one cycle after the strobe, zero otherwise
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= 32'h0000_0000;
      end
   end
endmodule

// ---- tb/ptad_assertions.sv ----
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module ptad_chk (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // words in
   input wire iw_valid,
   input wire [2:0] info_word_function_code,
   input wire [13:0] iw_content,
   input wire aw_valid,
   input wire [20:0] aw_word,
   // decoded results
   input wire time_upd_q,
   input wire [2:0] coarse_sec_q,
   input wire [5:0] minute_q,
   input wire [4:0] hour_q,
   input wire time_bad_q,
   input wire zone_upd_q,
   input wire std_time_q,
   input wire [4:0] zone_code_q,
   input wire [10:0] zone_off_q,
   input wire zone_rsvd_q,
   input wire addr_short_q,
   input wire addr_long_q,
   input wire addr_err_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire fc_time = iw_valid && info_word_function_code == 3'h2;
   wire fc_zone = iw_valid && info_word_function_code == 3'h5 && iw_content[3:1] == 3'b010;
   wire [2:0] s_hi = iw_content[13:11];
   wire [5:0] s_min = iw_content[10:5];
   wire [4:0] s_hr = iw_content[4:0];
   wire s_dst = iw_content[9];
   wire [4:0] s_zone = iw_content[8:4];
   wire any_pulse = addr_short_q || addr_long_q || addr_err_q;
   property p_time;
      fc_time |=> time_upd_q && coarse_sec_q == $past(s_hi) && minute_q == $past(s_min)
         && hour_q == $past(s_hr);
   endproperty
   a_time: assert property (p_time) else $error("time fields wrong");
   property p_nopulse;
      !fc_time |=> !time_upd_q;
   endproperty
   a_nopulse: assert property (p_nopulse) else $error("time pulse without code");
   property p_bad;
      time_upd_q |-> time_bad_q == (minute_q > 6'h3b || hour_q > 5'h17);
   endproperty
   a_bad: assert property (p_bad) else $error("range flag wrong");
   property p_zone;
      fc_zone |=> zone_upd_q && std_time_q == $past(s_dst) && zone_code_q == $past(s_zone);
   endproperty
   a_zone: assert property (p_zone) else $error("zone fields wrong");
   property p_nozone;
      !fc_zone |=> !zone_upd_q;
   endproperty
   a_nozone: assert property (p_nozone) else $error("zone pulse on other subtype");
   property p_rsvd;
      zone_upd_q |-> zone_rsvd_q == (zone_code_q == 5'h10);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
   property p_pos;
      zone_upd_q && zone_code_q <= 5'h0c |-> zone_off_q == {6'h00, zone_code_q} * 11'd60;
   endproperty
   a_pos: assert property (p_pos) else $error("positive offset wrong");
   property p_neg;
      zone_upd_q && zone_code_q >= 5'h15
         |-> zone_off_q == 11'd0 - (11'd32 - {6'h00, zone_code_q}) * 11'd60;
   endproperty
   a_neg: assert property (p_neg) else $error("negative offset wrong");
   property p_idle;
      aw_valid && (aw_word == 21'h000000 || aw_word == 21'h1fffff) |=> addr_err_q;
   endproperty
   a_idle: assert property (p_idle) else $error("idle word not refused");
   property p_one;
      !aw_valid |=> !any_pulse ##1 $onehot0({addr_short_q, addr_long_q, addr_err_q});
   endproperty
   a_one: assert property (p_one) else $error("address pulse wrong");
   c_bad: cover property (time_upd_q && time_bad_q);
   c_rsvd: cover property (zone_upd_q && zone_rsvd_q);
   c_long: cover property (addr_long_q);
endmodule

bind ptad_top ptad_chk u_chk (.mclk(mclk), .rst_n(rst_n), .iw_valid(iw_valid),
   .info_word_function_code(info_word_function_code), .iw_content(iw_content),
   .aw_valid(aw_valid), .aw_word(aw_word), .time_upd_q(time_upd_q),
   .coarse_sec_q(coarse_sec_q), .minute_q(minute_q), .hour_q(hour_q),
   .time_bad_q(time_bad_q), .zone_upd_q(zone_upd_q), .std_time_q(std_time_q),
   .zone_code_q(zone_code_q), .zone_off_q(zone_off_q), .zone_rsvd_q(zone_rsvd_q),
   .addr_short_q(addr_short_q), .addr_long_q(addr_long_q), .addr_err_q(addr_err_q));

// ---- tb/ptad_host.sv ----
// host side register master for the decoder
`timescale 1ns/1ps
module ptad_host (
   // clock
   input wire mclk,
   // register port
   output reg [4:0] reg_addr,
   output reg [31:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd,
   input wire [31:0] reg_rdata_q
);
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input [4:0] a, input [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe, so sample at the edge ending it
   task automatic rd(input [4:0] a, output [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata_q;
   endtask
endmodule

// ---- tb/ptad_top_tb.sv ----
// self-checking bench for the pager time and address decoder
`timescale 1ns/1ps
`include "ptad_defines.vh"
module ptad_top_tb;
   reg mclk = 1'b0;
   reg rst_n = 1'b0;
   reg iw_valid = 1'b0;
   reg [2:0] fc = 3'h0;
   reg [13:0] iw_content = 14'h0;
   reg aw_valid = 1'b0;
   reg [20:0] aw_word = 21'h0;
   reg frame_start = 1'b0;
   reg [6:0] frame_num = 7'h0;
   reg [1:0] phase_num = 2'h0;
   reg msg_found = 1'b0;
   wire [4:0] reg_addr, hour_q, zone_code_q;
   wire [31:0] reg_wdata, reg_rdata_q;
   wire reg_wr, reg_rd, time_upd_q, time_bad_q, zone_upd_q, std_time_q, zone_rsvd_q;
   wire addr_short_q, addr_long_q, addr_err_q, frame_watch_q, phase_seek_q;
   wire [2:0] coarse_sec_q;
   wire [5:0] minute_q, seconds_q;
   wire [10:0] zone_off_q;
   wire [3:0] addr_class_q;
   integer n_fail = 0, cmp_count = 0, cyc = 0, i, k;
   reg [15:0] lf = 16'h003e;
   reg [31:0] tq[$], zq[$], aq[$];
   reg [31:0] rv;
   reg [13:0] d;
   reg [2:0] cur_c = 3'h0, cur_a = 3'h0;
   reg [27:0] at [0:29];
   ptad_top uut (.mclk(mclk), .rst_n(rst_n), .iw_valid(iw_valid),
      .info_word_function_code(fc), .iw_content(iw_content), .aw_valid(aw_valid),
      .aw_word(aw_word), .frame_start(frame_start), .frame_num(frame_num),
      .phase_num(phase_num), .msg_found(msg_found), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .time_upd_q(time_upd_q), .coarse_sec_q(coarse_sec_q), .minute_q(minute_q),
      .hour_q(hour_q), .seconds_q(seconds_q), .time_bad_q(time_bad_q),
      .zone_upd_q(zone_upd_q), .std_time_q(std_time_q), .zone_code_q(zone_code_q),
      .zone_off_q(zone_off_q), .zone_rsvd_q(zone_rsvd_q), .addr_short_q(addr_short_q),
      .addr_long_q(addr_long_q), .addr_err_q(addr_err_q), .addr_class_q(addr_class_q),
      .frame_watch_q(frame_watch_q), .phase_seek_q(phase_seek_q));
   ptad_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
   initial forever #5 mclk = ~mclk;
   function [15:0] lfsr(input [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function [5:0] sec(input [2:0] c, input [2:0] a);
      sec = ((c * 8 + a) * 15) / 16;
   endfunction
   function [10:0] zexp(input [4:0] z);
      case (z)
         5'h0d: zexp = 11'd210;
         5'h0e: zexp = 11'd270;
         5'h0f: zexp = 11'd330;
         5'h10: zexp = 11'd0;
         5'h11: zexp = 11'd345;
         5'h12: zexp = 11'd390;
         5'h13: zexp = 11'd570;
         5'h14: zexp = 11'h72e;
         default: zexp = (z <= 5'h0c) ? {6'h0, z} * 11'd60 : 11'd0 - (11'd32 - z) * 11'd60;
      endcase
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task send_iw(input v, input [2:0] c, input [13:0] x);
      iw_valid <= v;
      fc <= c;
      iw_content <= x;
      @(posedge mclk);
   endtask
   task send_aw(input v, input [20:0] w);
      aw_valid <= v;
      aw_word <= w;
      @(posedge mclk);
   endtask
   task fs(input [6:0] n);
      frame_start <= 1'b1;
      frame_num <= n;
      @(posedge mclk);
      frame_start <= 1'b0;
      @(posedge mclk);
   endtask
   task ph(input [1:0] p, input m, input e);
      phase_num <= p;
      msg_found <= m;
      @(posedge mclk);
      msg_found <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(phase_seek_q, e);
   endtask
   // results are popped in arrival order; an unexpected pulse meets an empty queue
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (time_upd_q === 1'b1)
         chk({time_bad_q, seconds_q, hour_q, minute_q, coarse_sec_q},
            tq.size() ? tq.pop_front() : 32'hdead);
      if (zone_upd_q === 1'b1)
         chk({zone_rsvd_q, zone_off_q, zone_code_q, std_time_q, seconds_q},
            zq.size() ? zq.pop_front() : 32'hdead);
      if ((addr_short_q | addr_long_q | addr_err_q) !== 1'b0)
         chk({addr_err_q, addr_long_q, addr_short_q, addr_class_q},
            aq.size() ? aq.pop_front() : 32'hdead);
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         summarize;
      end
   end
   initial begin
      at = '{{21'h008001, 7'h12}, {21'h1e0000, 7'h12}, {21'h000000, 7'h40},
         {21'h1fffff, 7'h40}, {21'h1e0001, 7'h43}, {21'h1e8001, 7'h44}, {21'h1f0001, 7'h15},
         {21'h1f2800, 7'h16}, {21'h1f6800, 7'h17}, {21'h1f7800, 7'h18}, {21'h1f781f, 7'h19},
         {21'h1f7ffe, 7'h15}, {21'h000001, 7'h01}, {21'h1f7fff, 7'h2a}, {21'h008000, 7'h01},
         {21'h1e0001, 7'h23}, {21'h000005, 7'h01}, {21'h1f0000, 7'h24}, {21'h1f7fff, 7'h0a},
         {21'h1e8000, 7'h23}, {21'h1ffffe, 7'h0a}, {21'h1e8001, 7'h24}, {21'h000001, 7'h01},
         {21'h008001, 7'h42}, {21'h000001, 7'h01}, {21'h000001, 7'h41}, {21'h1f7fff, 7'h0a},
         {21'h1f7fff, 7'h4a}, {21'h1e0001, 7'h43}, {21'h1f27ff, 7'h15}};
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      host.rd(5'h00, rv);
      chk(rv, `PTAD_CFG_RESET);
      host.wr(5'h04, 32'hffffffff);
      host.rd(5'h04, rv);
      chk(rv, 32'h0);
      host.rd(5'h1c, rv);
      chk(rv, 32'h0);
      $display("register test done");
      for (i = 0; i < 32; i = i + 1) begin
         lf = lfsr(lf);
         cur_a = lf[2:0];
         zq.push_back({i == 16, zexp(i[4:0]), i[4:0], lf[3], sec(cur_c, cur_a)});
         send_iw(1'b1, `PTAD_FC_SYSMSG, {cur_a, lf[4], lf[3], i[4:0], 3'b010, i[0]});
         if (i[3:0] != 4 && i[3:0] != 5)
            send_iw(1'b1, `PTAD_FC_SYSMSG, {~cur_a, lf[4:3], i[4:0], i[3:0]});
      end
      send_iw(1'b0, 3'h0, 14'h0);
      $display("zone test done");
      for (i = 0; i < 40; i = i + 1) begin
         lf = lfsr(lf);
         d = (i == 0) ? 14'h3f77 : (i == 1) ? 14'h0798 : lf[13:0];
         cur_c = d[13:11];
         tq.push_back({d[10:5] > 59 || d[4:0] > 23, sec(cur_c, cur_a), d[4:0], d[10:5],
            d[13:11]});
         send_iw(1'b1, `PTAD_FC_TIME, d);
         if (i[2:0] != 2 && i[2:0] != 5) send_iw(1'b1, i[2:0], lf[13:0]);
      end
      send_iw(1'b0, 3'h0, 14'h0);
      host.rd(`PTAD_REG_TIME, rv);
      chk(rv, {1'b1, (d[10:5] > 59 || d[4:0] > 23), 2'h0, sec(cur_c, cur_a), 1'b0, d[4:0],
         2'h0, d[10:5], 5'h00, d[13:11]});
      $display("time test done");
      for (i = 0; i < 30; i = i + 1) begin
         if (at[i][6:4] != 0) aq.push_back(at[i][6:0]);
         send_aw(1'b1, at[i][27:7]);
      end
      send_aw(1'b0, 21'h0);
      repeat (3) @(posedge mclk);
      chk(tq.size() + zq.size() + aq.size(), 0);
      $display("address test done");
      for (k = 0; k < 4; k = k + 1) begin
         rv = (k == 0) ? 32'h0503 : (k == 1) ? 32'h0378 : (k == 2) ? 32'h0000 : 32'h077f;
         host.wr(5'h00, rv);
         for (i = 0; i < 128; i = i + 1) begin
            fs(i[6:0]);
            chk(frame_watch_q, ((i - rv[6:0] + 128) & ((1 << rv[10:8]) - 1)) == 0);
         end
      end
      $display("frame test done");
      host.wr(5'h00, 32'h2503);
      fs(7'd35);
      ph(2'd2, 1'b0, 1'b1);
      ph(2'd1, 1'b0, 1'b0);
      fs(7'd36);
      ph(2'd2, 1'b0, 1'b0);
      host.wr(5'h00, 32'h10503);
      fs(7'd35);
      ph(2'd0, 1'b0, 1'b1);
      ph(2'd1, 1'b1, 1'b1);
      ph(2'd3, 1'b0, 1'b0);
      fs(7'd67);
      ph(2'd3, 1'b0, 1'b1);
      host.wr(5'h00, 32'h20503);
      fs(7'd99);
      ph(2'd1, 1'b1, 1'b1);
      ph(2'd3, 1'b0, 1'b1);
      $display("phase test done");
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      host.rd(5'h00, rv);
      chk(rv, `PTAD_CFG_RESET);
      $display("second reset test done");
      summarize;
   end
endmodule
